// [rtl/periodic_tick_unit.sv]
// periodic tick unit: oscillator-driven divider chain with apb control
`timescale 1ns/1ps
`default_nettype none
module periodic_tick_unit (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic OSC_TICK,
    input wire tick_pkg::power_mode_t POWER_MODE,
    input wire logic STOP_OSC_KEEPALIVE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic TICK_IRQ,
    output logic WAKE_REQ,
    output logic IRQ
);
    import tick_pkg::*;

    logic tick_enable;
    logic tick_irq_enable;
    logic tick_flag;
    logic [RATE_W-1:0] tick_rate_select;
    logic [CHAIN_W-1:0] chain;
    logic [CHAIN_W-1:0] next_chain;
    logic chain_run;
    logic overflow;
    logic access;
    logic bus_blocked;
    logic ctrl_wr;
    logic ack_wr;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    logic [EV_W-1:0] ev;
    logic [31:0] next_rdata;
    logic [CHAIN_W:0] ticks_seen;
    logic first_due;

    // assertions below share the core clock and are masked during reset
    default clocking cb_core @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    // tap index for a rate code: code 0 taps bit 17, code 7 taps bit 10
    function automatic int tap_of(input logic [RATE_W-1:0] code);
        tap_of = CHAIN_W - 1 - int'(code);
    endfunction

    // apb access phase; control register blocked in wait and stop
    assign access = PSEL && PENABLE && !PREADY;
    assign bus_blocked = (POWER_MODE != RUN_MODE);
    assign ctrl_wr = access && PWRITE && !bus_blocked
        && (PADDR == TICK_CONTROL_ADDR);
    assign ack_wr = ctrl_wr && PWDATA[TICK_ACK_BIT];

    // chain runs in run and wait; in stop only with the keep-alive bit
    always_comb begin
        chain_run = tick_enable && OSC_TICK;
        if (POWER_MODE == STOP_MODE) begin
            chain_run = chain_run && STOP_OSC_KEEPALIVE;
        end
    end

    // the tap toggles high at half the period after a restart from zero,
    // giving the half-period first flag; later rises are a full period apart
    always_comb begin
        next_chain = chain + 18'h00001;
        overflow = chain_run && !chain[tap_of(tick_rate_select)]
            && next_chain[tap_of(tick_rate_select)];
    end

    // divider chain; cleared whenever disabled so re-enable starts at zero
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || !tick_enable) begin
            chain <= '0;
        end else if (chain_run) begin
            chain <= next_chain;
        end
    end

    // control bits; rate writes are accepted anyway, software must hold off
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            tick_enable <= TICK_CONTROL_RST[TICK_ENABLE_BIT];
            tick_irq_enable <= TICK_CONTROL_RST[TICK_IRQ_ENABLE_BIT];
            tick_rate_select <= TICK_CONTROL_RST[RATE_LSB +: RATE_W];
        end else if (ctrl_wr) begin
            tick_enable <= PWDATA[TICK_ENABLE_BIT];
            tick_irq_enable <= PWDATA[TICK_IRQ_ENABLE_BIT];
            tick_rate_select <= PWDATA[RATE_LSB +: RATE_W];
        end
    end

    // tick flag: overflow wins over a same-cycle acknowledge
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            tick_flag <= 1'b0;
        end else if (overflow) begin
            tick_flag <= 1'b1;
        end else if (ack_wr) begin
            tick_flag <= 1'b0;
        end
    end

    // interrupt request and stop wake-up come straight from flops
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            TICK_IRQ <= 1'b0;
            WAKE_REQ <= 1'b0;
        end else begin
            TICK_IRQ <= tick_flag && tick_irq_enable;
            WAKE_REQ <= tick_flag && tick_irq_enable
                && (POWER_MODE == STOP_MODE);
        end
    end

    // sticky event status, set wins over a clear in the same cycle
    assign ev[EV_TICK] = overflow;
    assign ev[EV_WAKE] = overflow && tick_irq_enable
        && (POWER_MODE == STOP_MODE);
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            irq_status <= IRQ_REG_RST;
            irq_enable <= IRQ_REG_RST;
        end else begin
            if (access && PWRITE && PADDR == IRQ_ENABLE_ADDR) begin
                irq_enable <= PWDATA[EV_W-1:0];
            end
            if (access && PWRITE && PADDR == IRQ_CLEAR_ADDR) begin
                irq_status <= (irq_status & ~PWDATA[EV_W-1:0]) | ev;
            end else begin
                irq_status <= irq_status | ev;
            end
        end
    end

    // level interrupt output
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_enable);
        end
    end

    // read mux; acknowledge always reads zero, unmapped reads zero
    always_comb begin
        next_rdata = 32'h00000000;
        case (PADDR)
            TICK_CONTROL_ADDR: begin
                next_rdata[TICK_ENABLE_BIT] = tick_enable;
                next_rdata[TICK_IRQ_ENABLE_BIT] = tick_irq_enable;
                next_rdata[TICK_ACK_BIT] = 1'b0;
                next_rdata[TICK_FLAG_BIT] = tick_flag;
                next_rdata[RATE_LSB +: RATE_W] = tick_rate_select;
            end
            IRQ_STATUS_ADDR: next_rdata[EV_W-1:0] = irq_status;
            IRQ_ENABLE_ADDR: next_rdata[EV_W-1:0] = irq_enable;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // one wait state: ready rises the cycle after penable
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= access;
            PSLVERR <= access && (bus_blocked
                && PADDR == TICK_CONTROL_ADDR
                || PADDR > IRQ_CLEAR_ADDR || PADDR[1:0] != 2'h0);
            if (access && !PWRITE) begin
                PRDATA <= (bus_blocked && PADDR == TICK_CONTROL_ADDR)
                    ? 32'h00000000 : next_rdata;
            end
        end
    end

    // independent count of oscillator ticks since the chain was enabled;
    // kept apart from the chain so the tick timing checks do not merely
    // restate the tap decode they are meant to guard
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || !tick_enable) begin
            ticks_seen <= '0;
        end else if (chain_run) begin
            ticks_seen <= ticks_seen + 19'h00001;
        end
    end

    // marks that the first flag after an enable is still to come
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || !tick_enable) begin
            first_due <= 1'b1;
        end else if (overflow) begin
            first_due <= 1'b0;
        end
    end

    // an accepted acknowledge that no overflow overrides
    sequence s_ack_accepted;
        ack_wr && !overflow;
    endsequence

    // flag drops at once, the request one cycle later
    sequence s_flag_then_irq_low;
        !tick_flag ##1 !TICK_IRQ;
    endsequence

    // an enabled tick while the device sits in stop
    sequence s_tick_in_stop;
        overflow && tick_irq_enable && POWER_MODE == STOP_MODE;
    endsequence

    // an access phase that the control register refuses
    sequence s_refused_ctrl;
        access && bus_blocked && PADDR == TICK_CONTROL_ADDR;
    endsequence

    // a refused read of the control register
    sequence s_refused_read;
        access && !PWRITE && bus_blocked && PADDR == TICK_CONTROL_ADDR;
    endsequence

    // the answer to any refused access
    sequence s_refused_answer;
        PREADY && PSLVERR;
    endsequence

    // acknowledge never leaks into read data
    a_ack_reads_zero: assert property (
        PREADY && !PWRITE && $past(PADDR) == TICK_CONTROL_ADDR
        |-> !PRDATA[TICK_ACK_BIT]
    ) else $error("ack bit read as one");

    // pending and enabled flag raises the request next cycle
    a_irq_follows_flag: assert property (
        tick_flag && tick_irq_enable |=> TICK_IRQ
    ) else $error("irq missing");

    // the request never appears without the enable behind it
    a_irq_needs_enable: assert property (
        TICK_IRQ |-> $past(tick_irq_enable)
    ) else $error("irq without enable");

    // the request drops once the flag is gone
    a_irq_drops_flag: assert property (
        !tick_flag |=> !TICK_IRQ
    ) else $error("irq without flag");

    // an overflow is never lost
    a_flag_set_overflow: assert property (
        overflow |=> tick_flag
    ) else $error("overflow lost");

    // only an overflow can raise the flag; bus writes cannot
    a_flag_rises_cause: assert property (
        $rose(tick_flag) |-> $past(overflow)
    ) else $error("flag set without cause");

    // only an acknowledge can lower the flag
    a_flag_falls_cause: assert property (
        $fell(tick_flag) |-> $past(ack_wr)
    ) else $error("flag cleared without ack");

    // an accepted acknowledge clears the flag
    a_flag_ack_clear: assert property (
        ack_wr && !overflow |=> !tick_flag
    ) else $error("ack ignored");

    // acknowledge quiets the request within two cycles
    a_ack_quiets_irq: assert property (
        s_ack_accepted |=> s_flag_then_irq_low
    ) else $error("irq stayed after ack");

    // a control write with the acknowledge bit low keeps the flag
    a_ack_zero_keeps: assert property (
        ctrl_wr && !PWDATA[TICK_ACK_BIT] && tick_flag |=> tick_flag
    ) else $error("flag lost on plain write");

    // a disabled chain sits at zero
    a_chain_held_off: assert property (
        !tick_enable |=> chain == '0
    ) else $error("chain not held");

    // each oscillator tick advances the chain by exactly one
    a_chain_counts: assert property (
        chain_run |=> chain == $past(chain) + 18'h00001
    ) else $error("chain missed a tick");

    // without an oscillator tick the chain does not move
    a_chain_waits_tick: assert property (
        tick_enable && !OSC_TICK |=> $stable(chain)
    ) else $error("chain moved without tick");

    // first flag after an enable comes at half the divider
    a_first_tick_half: assert property (
        first_due && overflow
        |-> ticks_seen + 19'h00001
            == (19'h00001 << tap_of(tick_rate_select))
    ) else $error("first tick mistimed");

    // later flags keep the full divider spacing
    a_later_ticks_period: assert property (
        !first_due && overflow
        |-> ((ticks_seen + 19'h00001)
            & ((19'h00001 << (tap_of(tick_rate_select) + 1)) - 19'h00001))
            == (19'h00001 << tap_of(tick_rate_select))
    ) else $error("later tick mistimed");

    // no keep-alive in stop: the chain stays frozen
    a_stop_chain_frozen: assert property (
        POWER_MODE == STOP_MODE && !STOP_OSC_KEEPALIVE && tick_enable
        |=> $stable(chain)
    ) else $error("chain ran in stop");

    // wait mode keeps the chain counting
    a_wait_chain_runs: assert property (
        POWER_MODE == WAIT_MODE && tick_enable && OSC_TICK
        |=> chain != $past(chain)
    ) else $error("chain stalled in wait");

    // low-power modes leave the control bits untouched
    a_ctrl_blocked: assert property (
        access && POWER_MODE != RUN_MODE
        |=> $stable(tick_enable) && $stable(tick_rate_select)
    ) else $error("write in low power");

    // a refused control access is answered with an error
    a_refused_error: assert property (
        s_refused_ctrl |=> s_refused_answer
    ) else $error("refused access not flagged");

    // a refused control read returns zero
    a_refused_reads_zero: assert property (
        s_refused_read |=> PRDATA == 32'h00000000
    ) else $error("refused read leaked data");

    // an enabled tick in stop raises the wake-up request
    a_stop_wakes: assert property (
        s_tick_in_stop ##1 (POWER_MODE == STOP_MODE && tick_irq_enable)
        |=> WAKE_REQ
    ) else $error("no wake from stop");

    // wake-up is only requested out of stop
    a_wake_needs_stop: assert property (
        WAKE_REQ |-> $past(POWER_MODE == STOP_MODE)
    ) else $error("wake outside stop");

    // each access phase gets exactly one ready pulse
    a_ready_pulse: assert property (
        access |=> PREADY ##1 !PREADY
    ) else $error("ready not a single pulse");

    // the error flag only rides on ready
    a_slverr_with_ready: assert property (
        PSLVERR |-> PREADY
    ) else $error("error without ready");

    // leaving reset finds enables, flag and chain cleared
    a_reset_clears: assert property (
        $rose(RESET_N)
        |-> !tick_enable && !tick_irq_enable && !tick_flag && chain == '0
    ) else $error("reset left state behind");
endmodule
`default_nettype wire

// [include/tick_pkg.sv]
// constants shared by the periodic tick unit
package tick_pkg;
    // apb register map (byte addresses)
    localparam logic [7:0] TICK_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h04;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h0C;
    // tick_control field positions
    localparam int TICK_ENABLE_BIT = 0;
    localparam int TICK_IRQ_ENABLE_BIT = 1;
    localparam int TICK_ACK_BIT = 2;
    localparam int TICK_FLAG_BIT = 3;
    localparam int RATE_LSB = 4;
    localparam int RATE_W = 3;
    // chain geometry
    localparam int CHAIN_W = 18;
    localparam int OSC_FREQ_HZ = 88000;
    localparam int MIN_TAP = 10;
    // reset values
    localparam logic [7:0] TICK_CONTROL_RST = 8'h00;
    localparam logic [1:0] IRQ_REG_RST = 2'h0;
    // interrupt status bits: tick and wake-up
    localparam int EV_TICK = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_W = 2;
    typedef enum logic [1:0] {
        RUN_MODE,
        WAIT_MODE,
        STOP_MODE
    } power_mode_t;
endpackage

// [tb/test_periodic_tick_unit.sv]
// self-checking bench for the periodic tick unit over apb
`timescale 1ns/1ps
`default_nettype none
module test_periodic_tick_unit;
    import tick_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, osc = 1'b1, keep = 1'b0;
    power_mode_t mode = RUN_MODE;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, rerr, tick_irq, wake, irq;
    int mismatches = 0, n_compared = 0;
    periodic_tick_unit periodic_tick_unit_i (.CORE_CLK(clk), .RESET_N(rst_n),
        .OSC_TICK(osc), .POWER_MODE(mode), .STOP_OSC_KEEPALIVE(keep),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TICK_IRQ(tick_irq), .WAKE_REQ(wake), .IRQ(irq));
    // 200 MHz core clock
    always #2.5 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(1'b0, 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // watchdog: whole run is about 14k cycles
    initial begin
        cyc(60000);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        cyc(2);
        rst_n <= 1'b1;
        rd_chk(TICK_CONTROL_ADDR, 32'h0);
        rd_chk(IRQ_STATUS_ADDR, 32'h0);
        rd_chk(8'h10, 32'h0);
        check(rerr, 1'b1);
        // every rate code is held in the field
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, TICK_CONTROL_ADDR, c << RATE_LSB);
            rd_chk(TICK_CONTROL_ADDR, c << RATE_LSB);
        end
        $display("reset and field test done");
        // code 7: first flag after 1024 ticks, then every 2048
        apb(1'b1, IRQ_ENABLE_ADDR, 32'h1);
        apb(1'b1, TICK_CONTROL_ADDR, 32'h73);
        cyc(1000);
        rd_chk(TICK_CONTROL_ADDR, 32'h73);
        cyc(30);
        rd_chk(TICK_CONTROL_ADDR, 32'h7B);
        check(tick_irq, 1'b1);
        check(irq, 1'b1);
        rd_chk(IRQ_STATUS_ADDR, 32'h1);
        apb(1'b1, IRQ_CLEAR_ADDR, 32'h1);
        rd_chk(IRQ_STATUS_ADDR, 32'h0);
        check(irq, 1'b0);
        // ack with the flag bit also written as one
        apb(1'b1, TICK_CONTROL_ADDR, 32'h7F);
        rd_chk(TICK_CONTROL_ADDR, 32'h73);
        apb(1'b1, TICK_CONTROL_ADDR, 32'h73);
        cyc(1900);
        rd_chk(TICK_CONTROL_ADDR, 32'h73);
        cyc(150);
        rd_chk(TICK_CONTROL_ADDR, 32'h7B);
        apb(1'b1, TICK_CONTROL_ADDR, 32'h77);
        cyc(2);
        check(tick_irq, 1'b0);
        $display("periodic test done");
        // wait mode: register refused, chain still runs
        mode <= WAIT_MODE;
        rd_chk(TICK_CONTROL_ADDR, 32'h0);
        check(rerr, 1'b1);
        cyc(2100);
        check(tick_irq, 1'b1);
        apb(1'b1, TICK_CONTROL_ADDR, 32'h00);
        check(rerr, 1'b1);
        mode <= RUN_MODE;
        rd_chk(TICK_CONTROL_ADDR, 32'h7B);
        apb(1'b1, TICK_CONTROL_ADDR, 32'h77);
        // stop mode without and with keep-alive
        mode <= STOP_MODE;
        cyc(2200);
        check(tick_irq, 1'b0);
        check(wake, 1'b0);
        rd_chk(TICK_CONTROL_ADDR, 32'h0);
        check(rerr, 1'b1);
        keep <= 1'b1;
        cyc(2200);
        check(wake, 1'b1);
        mode <= RUN_MODE;
        keep <= 1'b0;
        cyc(3);
        check(wake, 1'b0);
        $display("low power test done");
        // disable clears the chain; restart gives a half period again
        apb(1'b1, TICK_CONTROL_ADDR, 32'h04);
        apb(1'b1, TICK_CONTROL_ADDR, 32'h61);
        cyc(2000);
        rd_chk(TICK_CONTROL_ADDR, 32'h61);
        cyc(80);
        rd_chk(TICK_CONTROL_ADDR, 32'h69);
        check(tick_irq, 1'b0);
        // chain only advances on oscillator ticks
        apb(1'b1, TICK_CONTROL_ADDR, 32'h04);
        osc <= 1'b0;
        apb(1'b1, TICK_CONTROL_ADDR, 32'h71);
        cyc(1100);
        rd_chk(TICK_CONTROL_ADDR, 32'h71);
        osc <= 1'b1;
        cyc(1030);
        rd_chk(TICK_CONTROL_ADDR, 32'h79);
        // a second reset drops enables
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rd_chk(TICK_CONTROL_ADDR, 32'h0);
        $display("restart test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
